// >>> pkg/fmdi_params.svh
`ifndef FMDI_PARAMS_SVH
`define FMDI_PARAMS_SVH

// ****************************************************************
// Register offsets on the internal instruction bus.
// ****************************************************************
`define FMDI_ADR_CTRL0_LOW      24'h080000
`define FMDI_ADR_CTRL0_HIGH     24'h080002
`define FMDI_ADR_CTRL1_LOW      24'h080004
`define FMDI_ADR_CTRL1_HIGH     24'h080006
`define FMDI_ADR_WDATA0_LOW     24'h080008
`define FMDI_ADR_WDATA0_HIGH    24'h08000a
`define FMDI_ADR_WDATA1_LOW     24'h08000c
`define FMDI_ADR_WDATA1_HIGH    24'h08000e
`define FMDI_ADR_TARGET_LOW     24'h080010
`define FMDI_ADR_TARGET_HIGH    24'h080012
`define FMDI_ADR_FAULT          24'h080014
`define FMDI_ADR_NV_WP_I        24'h08dfb0
`define FMDI_ADR_NV_AP0         24'h08dfb8
`define FMDI_ADR_NV_AP1_LOW     24'h08dfbc
`define FMDI_ADR_NV_AP1_HIGH    24'h08dfbe

// ****************************************************************
// Register offsets on the peripheral and special-function buses.
// ****************************************************************
`define FMDI_ADR_TEMP_UNPROT0   16'heb50
`define FMDI_ADR_PROG_ID        16'hf078
`define FMDI_ADR_MEMORY_ID      16'hf07a
`define FMDI_ADR_CHIP_ID        16'hf07c
`define FMDI_ADR_MAKER_ID       16'hf07e

// ****************************************************************
// Reset values.
// ****************************************************************
`define FMDI_RST_CTRL           16'h0000
`define FMDI_RST_WDATA          16'hffff
`define FMDI_RST_NV_AP0         16'hacff
`define FMDI_RST_NV_OTHER       16'hffff
`define FMDI_RST_TEMP_UNPROT0   16'h0000
`define FMDI_RST_PROG_ID        16'h0040

// ****************************************************************
// Identification fields.
// ****************************************************************
`define FMDI_KIND_MSB           15
`define FMDI_KIND_LSB           12
`define FMDI_CAP_MSB            11
`define FMDI_CAP_LSB            0
`define FMDI_POLL_HI            15
`define FMDI_POLL_LO            14
`define FMDI_CAP_VALUE          12'h040
`define FMDI_KIND_HPFLASH       4'h3
`define FMDI_KIND_PREINIT       4'hf
`define FMDI_VDD_VALUE          8'h40
`define FMDI_VPP_VALUE          8'h00
`define FMDI_MAKER_LOW          5'h03
`define FMDI_NREG               15

`endif

// >>> pkg/fmdi_pkg.sv
`default_nettype none
package fmdi_pkg;

  typedef logic [3:0] fmdi_idx_type;

  typedef struct packed {
    logic        sel;
    logic        we;
    logic        word;
    logic [23:0] addr;
    logic [15:0] wdata;
  } fmdi_req_type;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic [15:0] rdata;
  } fmdi_rsp_type;

  typedef enum logic [2:0] {
    FMDI_ST_STRAP = 3'b001,
    FMDI_ST_WAIT  = 3'b010,
    FMDI_ST_READY = 3'b100
  } fmdi_state_type;

endpackage
`default_nettype wire

// >>> rtl/fmdi_bank.sv
// How it works
// - Flash registers on instruction bus, unprotect on peripheral.
// - Only word accesses write; bit operations refused except in special space.
// - Four read-only identification words in special space.
// - Capacity field reads 040h for 256 kilobytes.
// - Storage kind field reports high-performance flash, 3h.
// - Program supply field reads 40h for five volts.
// - External program supply field reads 00h.
// - Chip word carries revision nibble in low bits.
// - Maker word holds normalized maker code.
// - Before flash init, identification shows defaults.
// - Access pin high at reset means ready at once.
// - Bits 15 and 14 of memory word flag init.
// - Pre-init memory word F040h, programming word 0040h.
// - Data halves reset FFFFh, control, target and fault 0000h.
// - Access protection 0 resets ACFFh, others FFFFh.
// - Temporary unprotection register resets to 0000h.
`timescale 1ns/100ps
`default_nettype none
`include "fmdi_params.svh"

module fmdi_bank #(
  parameter logic [11:0] DEVICE_CODE   = 12'h5a5,
  parameter logic [3:0]  REVISION_CODE = 4'h1,
  parameter logic [10:0] MAKER_CODE    = 11'h2a5
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  external_access_pin,
  input  wire logic                  flash_init_done,
  input  wire fmdi_pkg::fmdi_req_type ib_req,
  output var  fmdi_pkg::fmdi_rsp_type ib_rsp,
  input  wire fmdi_pkg::fmdi_req_type xb_req,
  output var  fmdi_pkg::fmdi_rsp_type xb_rsp,
  input  wire fmdi_pkg::fmdi_req_type sf_req,
  output var  fmdi_pkg::fmdi_rsp_type sf_rsp,
  output logic [14:0][15:0]          flash_q,
  output logic [15:0]                temp_unprotect0,
  output logic                       id_valid
);

  // ****************************************************************
  // Decoding functions.
  // ****************************************************************
  // The top bit of the result marks a hit in the flash register set.
  function automatic logic [4:0] ib_decode(input logic [23:0] a);
    logic [4:0] r;
    r = 5'h00;
    case (a)
      `FMDI_ADR_CTRL0_LOW:   r = 5'h10;
      `FMDI_ADR_CTRL0_HIGH:  r = 5'h11;
      `FMDI_ADR_CTRL1_LOW:   r = 5'h12;
      `FMDI_ADR_CTRL1_HIGH:  r = 5'h13;
      `FMDI_ADR_WDATA0_LOW:  r = 5'h14;
      `FMDI_ADR_WDATA0_HIGH: r = 5'h15;
      `FMDI_ADR_WDATA1_LOW:  r = 5'h16;
      `FMDI_ADR_WDATA1_HIGH: r = 5'h17;
      `FMDI_ADR_TARGET_LOW:  r = 5'h18;
      `FMDI_ADR_TARGET_HIGH: r = 5'h19;
      `FMDI_ADR_FAULT:       r = 5'h1a;
      `FMDI_ADR_NV_WP_I:     r = 5'h1b;
      `FMDI_ADR_NV_AP0:      r = 5'h1c;
      `FMDI_ADR_NV_AP1_LOW:  r = 5'h1d;
      `FMDI_ADR_NV_AP1_HIGH: r = 5'h1e;
      default:               r = 5'h00;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] reset_value(input int i);
    logic [15:0] v;
    v = `FMDI_RST_CTRL;
    case (i)
      4, 5, 6, 7: v = `FMDI_RST_WDATA;
      12:         v = `FMDI_RST_NV_AP0;
      11, 13, 14: v = `FMDI_RST_NV_OTHER;
      default:    v = `FMDI_RST_CTRL;
    endcase
    return v;
  endfunction

  // Only word-wide accesses are written; bit-addressed accesses never are.
  function automatic logic wr_ok(input fmdi_pkg::fmdi_req_type q);
    return q.sel && q.we && q.word;
  endfunction

  // ****************************************************************
  // Flash initialization tracking.
  // ****************************************************************
  logic                     ea_s1;
  logic                     ea_s2;
  logic                     ea_s3;
  fmdi_pkg::fmdi_state_type state;
  fmdi_pkg::fmdi_state_type next_state;
  wire                      ea_settled;

  assign ea_settled = (ea_s2 == ea_s3);

  // The synchroniser runs through reset, so the strap level held during
  // reset has settled when reset lets go and no false low is seen.
  always_ff @(posedge mclk) begin
    ea_s1 <= external_access_pin;
    ea_s2 <= ea_s1;
    ea_s3 <= ea_s2;
  end

  // The strap is taken once after reset, when the synchroniser agrees.
  always_comb begin
    next_state = state;
    case (state)
      fmdi_pkg::FMDI_ST_STRAP: begin
        if (flash_init_done) begin
          next_state = fmdi_pkg::FMDI_ST_READY;
        end else if (ea_settled && ea_s3) begin
          next_state = fmdi_pkg::FMDI_ST_READY;
        end else if (ea_settled) begin
          next_state = fmdi_pkg::FMDI_ST_WAIT;
        end
      end
      fmdi_pkg::FMDI_ST_WAIT: begin
        if (flash_init_done) begin
          next_state = fmdi_pkg::FMDI_ST_READY;
        end
      end
      fmdi_pkg::FMDI_ST_READY: begin
        next_state = fmdi_pkg::FMDI_ST_READY;
      end
      default: begin
        next_state = fmdi_pkg::FMDI_ST_STRAP;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= fmdi_pkg::FMDI_ST_STRAP;
    end else begin
      state <= next_state;
    end
  end

  assign id_valid = (state == fmdi_pkg::FMDI_ST_READY);

  // ****************************************************************
  // Identification words.
  // ****************************************************************
  wire [3:0]  kind_field;
  wire [15:0] memory_id;
  wire [15:0] programming_voltage_id;
  wire [15:0] chip_id;
  wire [15:0] maker_id;

  // Kind reads all ones until ready, so the polled bits read 11.
  assign kind_field = id_valid ? `FMDI_KIND_HPFLASH
                               : `FMDI_KIND_PREINIT;
  assign memory_id  = {kind_field, `FMDI_CAP_VALUE};
  assign programming_voltage_id =
    {`FMDI_VPP_VALUE, `FMDI_VDD_VALUE};
  assign chip_id  = {DEVICE_CODE, REVISION_CODE};
  assign maker_id = {MAKER_CODE, `FMDI_MAKER_LOW};

  // ****************************************************************
  // Special-function space: identification words.
  // ****************************************************************
  wire [15:0] sf_addr;
  wire        sf_hit;
  logic [15:0] sf_word;

  assign sf_addr = sf_req.addr[15:0];

  always_comb begin
    case (sf_addr)
      `FMDI_ADR_PROG_ID:   sf_word = programming_voltage_id;
      `FMDI_ADR_MEMORY_ID: sf_word = memory_id;
      `FMDI_ADR_CHIP_ID:   sf_word = chip_id;
      `FMDI_ADR_MAKER_ID:  sf_word = maker_id;
      default:             sf_word = 16'h0000;
    endcase
  end

  assign sf_hit = (sf_addr == `FMDI_ADR_PROG_ID)
               || (sf_addr == `FMDI_ADR_MEMORY_ID)
               || (sf_addr == `FMDI_ADR_CHIP_ID)
               || (sf_addr == `FMDI_ADR_MAKER_ID);

  // Writes are acknowledged and dropped; reads change nothing.
  always_ff @(posedge mclk) begin
    if (rst) begin
      sf_rsp <= '0;
    end else begin
      sf_rsp.ack   <= sf_req.sel;
      sf_rsp.err   <= sf_req.sel && !sf_hit;
      sf_rsp.rdata <= (sf_req.sel && !sf_req.we) ? sf_word
                                                 : 16'h0000;
    end
  end

  // ****************************************************************
  // Instruction bus: flash control registers.
  // ****************************************************************
  wire [4:0]              ib_dec;
  wire                    ib_hit;
  fmdi_pkg::fmdi_idx_type ib_idx;
  wire                    ib_write;
  wire                    ib_read;

  assign ib_dec   = ib_decode(ib_req.addr);
  assign ib_hit   = ib_dec[4];
  assign ib_idx   = ib_dec[3:0];
  assign ib_write = wr_ok(ib_req) && ib_hit;
  assign ib_read  = ib_req.sel && !ib_req.we && ib_req.word && ib_hit;

  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < `FMDI_NREG; i++) begin
        flash_q[i] <= reset_value(i);
      end
    end else if (ib_write) begin
      flash_q[ib_idx] <= ib_req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ib_rsp <= '0;
    end else begin
      ib_rsp.ack   <= ib_req.sel;
      ib_rsp.err   <= ib_req.sel && (!ib_hit || !ib_req.word);
      ib_rsp.rdata <= ib_read ? flash_q[ib_idx] : 16'h0000;
    end
  end

  // ****************************************************************
  // Peripheral bus: temporary unprotection register.
  // ****************************************************************
  wire xb_hit;
  wire xb_write;
  wire xb_read;

  assign xb_hit   = (xb_req.addr[15:0] == `FMDI_ADR_TEMP_UNPROT0);
  assign xb_write = wr_ok(xb_req) && xb_hit;
  assign xb_read  = xb_req.sel && !xb_req.we && xb_req.word && xb_hit;

  always_ff @(posedge mclk) begin
    if (rst) begin
      temp_unprotect0 <= `FMDI_RST_TEMP_UNPROT0;
    end else if (xb_write) begin
      temp_unprotect0 <= xb_req.wdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      xb_rsp <= '0;
    end else begin
      xb_rsp.ack   <= xb_req.sel;
      xb_rsp.err   <= xb_req.sel && (!xb_hit || !xb_req.word);
      xb_rsp.rdata <= xb_read ? temp_unprotect0 : 16'h0000;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  sequence seq_mem_read;
    sf_req.sel && !sf_req.we && (sf_addr == `FMDI_ADR_MEMORY_ID);
  endsequence

  sequence seq_strap_high;
    (state == fmdi_pkg::FMDI_ST_STRAP) && ea_s2 && ea_s3;
  endsequence

  a_mem_pre_init: assert property (
    @(posedge mclk) disable iff (rst)
    seq_mem_read ##0 !id_valid |=> sf_rsp.rdata == 16'hf040
  ) else $error("memory word wrong before init");

  a_mem_ready: assert property (
    @(posedge mclk) disable iff (rst)
    seq_mem_read ##0 id_valid |=> sf_rsp.rdata == 16'h3040
  ) else $error("memory word wrong after init");

  a_poll_bits: assert property (
    @(posedge mclk) disable iff (rst)
    memory_id[15:14] == (id_valid ? 2'b00 : 2'b11)
  ) else $error("init poll bits do not match state");

  a_prog_word: assert property (
    @(posedge mclk) disable iff (rst)
    sf_req.sel && !sf_req.we && (sf_addr == `FMDI_ADR_PROG_ID)
    |=> sf_rsp.ack && sf_rsp.rdata == 16'h0040
  ) else $error("programming word wrong");

  a_strap_ready: assert property (
    @(posedge mclk) disable iff (rst)
    seq_strap_high |=> id_valid
  ) else $error("high strap did not make words ready");

  a_wait_init: assert property (
    @(posedge mclk) disable iff (rst)
    (state == fmdi_pkg::FMDI_ST_WAIT) && !flash_init_done |=> !id_valid
  ) else $error("words ready before init finished");

  a_ib_word_wr: assert property (
    @(posedge mclk) disable iff (rst)
    ib_write |=> flash_q[$past(ib_idx)] == $past(ib_req.wdata)
  ) else $error("flash register write lost");

  a_ib_bit_op: assert property (
    @(posedge mclk) disable iff (rst)
    ib_req.sel && ib_req.we && !ib_req.word
    |=> $stable(flash_q) && ib_rsp.err
  ) else $error("bit access altered a flash register");

  a_id_no_side: assert property (
    @(posedge mclk) disable iff (rst)
    sf_req.sel && !ib_write ##1 1'b1 |-> $stable(flash_q)
  ) else $error("identification access disturbed flash state");

  a_flash_reset: assert property (
    @(posedge mclk) disable iff (rst)
    $past(rst) |-> flash_q[4] == 16'hffff && flash_q[0] == 16'h0000
                && flash_q[10] == 16'h0000
  ) else $error("flash reset values wrong");

  a_prot_reset: assert property (
    @(posedge mclk) disable iff (rst)
    $past(rst) |-> flash_q[12] == 16'hacff && flash_q[11] == 16'hffff
                && flash_q[14] == 16'hffff
  ) else $error("protection reset values wrong");

  a_unprot_reset: assert property (
    @(posedge mclk) disable iff (rst)
    $past(rst) |-> temp_unprotect0 == 16'h0000
  ) else $error("unprotection reset value wrong");

  a_xb_write: assert property (
    @(posedge mclk) disable iff (rst)
    xb_write |=> temp_unprotect0 == $past(xb_req.wdata)
  ) else $error("unprotection write lost");

  a_id_write: assert property (
    @(posedge mclk) disable iff (rst)
    sf_req.sel && sf_req.we |=> sf_rsp.ack && sf_rsp.rdata == 16'h0000
                                && $stable(chip_id) && $stable(maker_id)
  ) else $error("identification write had effect");

  a_ib_ack_pulse: assert property (
    @(posedge mclk) disable iff (rst)
    ib_req.sel |=> ib_rsp.ack
  ) else $error("instruction bus access not acknowledged");

  a_xb_bit_op: assert property (
    @(posedge mclk) disable iff (rst)
    xb_req.sel && xb_req.we && !xb_req.word
    |=> $stable(temp_unprotect0) && xb_rsp.err
  ) else $error("bit access altered the unprotection register");

  a_ready_hold: assert property (
    @(posedge mclk) disable iff (rst)
    id_valid |=> id_valid
  ) else $error("identification words lost validity");

  a_sf_unmapped: assert property (
    @(posedge mclk) disable iff (rst)
    sf_req.sel && !sf_hit
    |=> sf_rsp.err && sf_rsp.rdata == 16'h0000
  ) else $error("unmapped identification access not refused");

  a_chip_word: assert property (
    @(posedge mclk) disable iff (rst)
    sf_req.sel && !sf_req.we && (sf_addr == `FMDI_ADR_CHIP_ID)
    |=> sf_rsp.rdata == {DEVICE_CODE, REVISION_CODE}
  ) else $error("chip word wrong");

  a_maker_word: assert property (
    @(posedge mclk) disable iff (rst)
    sf_req.sel && !sf_req.we && (sf_addr == `FMDI_ADR_MAKER_ID)
    |=> sf_rsp.rdata == {MAKER_CODE, 5'h03}
  ) else $error("maker word wrong");

endmodule
`default_nettype wire

// >>> bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "fmdi_params.svh"

module tb;

  // ****************************************************************
  // Identity values are arbitrary and belong to no real part.
  // ****************************************************************
  localparam logic [11:0] DEV_CODE  = 12'h3c7;
  localparam logic [3:0]  REV_CODE  = 4'h2;
  localparam logic [10:0] MAK_CODE  = 11'h155;
  localparam logic [15:0] CHIP_EXP  = {DEV_CODE, REV_CODE};
  localparam logic [15:0] MAKER_EXP = {MAK_CODE, 5'h03};

  typedef struct packed {
    logic [1:0]  bus;
    logic        we;
    logic        word;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        err;
  } fmdi_row_type;

  logic                   mclk;
  logic                   rst;
  logic                   external_access_pin;
  logic                   flash_init_done;
  fmdi_pkg::fmdi_req_type ib_req;
  fmdi_pkg::fmdi_rsp_type ib_rsp;
  fmdi_pkg::fmdi_req_type xb_req;
  fmdi_pkg::fmdi_rsp_type xb_rsp;
  fmdi_pkg::fmdi_req_type sf_req;
  fmdi_pkg::fmdi_rsp_type sf_rsp;
  logic [14:0][15:0]      flash_q;
  logic [15:0]            temp_unprotect0;
  logic                   id_valid;
  int                     fails;
  int                     cmp_count;
  fmdi_row_type           rows [$];
  logic [23:0]            fl_addr [15];
  logic [15:0]            fl_rst [15];

  fmdi_bank #(
    .DEVICE_CODE   (DEV_CODE),
    .REVISION_CODE (REV_CODE),
    .MAKER_CODE    (MAK_CODE)
  ) u_fmdi_bank (
    .mclk                (mclk),
    .rst                 (rst),
    .external_access_pin (external_access_pin),
    .flash_init_done     (flash_init_done),
    .ib_req              (ib_req),
    .ib_rsp              (ib_rsp),
    .xb_req              (xb_req),
    .xb_rsp              (xb_rsp),
    .sf_req              (sf_req),
    .sf_rsp              (sf_rsp),
    .flash_q             (flash_q),
    .temp_unprotect0     (temp_unprotect0),
    .id_valid            (id_valid)
  );

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  task automatic report_and_stop;
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  function automatic fmdi_pkg::fmdi_rsp_type pick(input logic [1:0] bus);
    case (bus)
      2'h0: return ib_rsp;
      2'h1: return xb_rsp;
      default: return sf_rsp;
    endcase
  endfunction

  function automatic fmdi_row_type mk(input logic [1:0] b, input logic we,
      input logic wo, input logic [23:0] a, input logic [15:0] wd,
      input logic [15:0] rd, input logic er);
    return {b, we, wo, a, wd, rd, er};
  endfunction

  // One access is a single-cycle select; the answer is awaited boundedly.
  task automatic bus_op(input logic [1:0] bus, input logic we,
      input logic wo, input logic [23:0] a, input logic [15:0] wd,
      output logic [15:0] rd, output logic er);
    fmdi_pkg::fmdi_req_type r;
    fmdi_pkg::fmdi_rsp_type s;
    int n;
    r = {1'b1, we, wo, a, wd};
    @(negedge mclk);
    if (bus == 2'h0) ib_req = r;
    else if (bus == 2'h1) xb_req = r;
    else sf_req = r;
    @(negedge mclk);
    ib_req = '0;
    xb_req = '0;
    sf_req = '0;
    n = 0;
    s = pick(bus);
    while (s.ack !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
      s = pick(bus);
    end
    if (s.ack !== 1'b1) begin
      fails++;
      $display("[ERR] %0t: no acknowledge", $time);
    end
    rd = s.rdata;
    er = s.err;
  endtask

  task automatic expect_op(input fmdi_row_type w);
    logic [15:0] rd;
    logic        er;
    bus_op(w.bus, w.we, w.word, w.addr, w.wdata, rd, er);
    check(rd, w.rdata);
    check({15'h0000, er}, {15'h0000, w.err});
  endtask

  initial begin
    #50000;
    fails++;
    report_and_stop();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    int          i;
    logic [15:0] v;
    logic        e;
    rst = 1'b1;
    external_access_pin = 1'b0;
    flash_init_done = 1'b0;
    ib_req = '0;
    xb_req = '0;
    sf_req = '0;
    fails = 0;
    cmp_count = 0;
    fl_addr = '{24'h080000, 24'h080002, 24'h080004, 24'h080006,
      24'h080008, 24'h08000a, 24'h08000c, 24'h08000e, 24'h080010,
      24'h080012, 24'h080014, 24'h08dfb0, 24'h08dfb8, 24'h08dfbc,
      24'h08dfbe};
    fl_rst = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hffff,
      16'hffff, 16'hffff, 16'hffff, 16'h0000, 16'h0000, 16'h0000,
      16'hffff, 16'hacff, 16'hffff, 16'hffff};
    rows.push_back(mk(2'h2, 0, 1, 24'h00f07a, 16'h0000, 16'h3040, 0));
    rows.push_back(mk(2'h2, 0, 1, 24'h00f078, 16'h0000, 16'h0040, 0));
    rows.push_back(mk(2'h2, 0, 1, 24'h00f07c, 16'h0000, CHIP_EXP, 0));
    rows.push_back(mk(2'h2, 0, 1, 24'h00f07e, 16'h0000, MAKER_EXP, 0));
    rows.push_back(mk(2'h2, 1, 1, 24'h00f07c, 16'h0000, 16'h0000, 0));
    rows.push_back(mk(2'h2, 1, 1, 24'h00f07a, 16'hffff, 16'h0000, 0));
    rows.push_back(mk(2'h2, 0, 1, 24'h00f07c, 16'h0000, CHIP_EXP, 0));
    rows.push_back(mk(2'h2, 0, 1, 24'h00f07a, 16'h0000, 16'h3040, 0));
    rows.push_back(mk(2'h2, 0, 1, 24'h00f080, 16'h0000, 16'h0000, 1));
    rows.push_back(mk(2'h0, 1, 0, 24'h080000, 16'h1234, 16'h0000, 1));
    rows.push_back(mk(2'h0, 0, 1, 24'h080000, 16'h0000, 16'h0000, 0));
    rows.push_back(mk(2'h1, 1, 1, 24'h00eb50, 16'ha55a, 16'h0000, 0));
    rows.push_back(mk(2'h1, 1, 0, 24'h00eb50, 16'hffff, 16'h0000, 1));
    rows.push_back(mk(2'h1, 0, 1, 24'h00eb50, 16'h0000, 16'ha55a, 0));
    rows.push_back(mk(2'h0, 0, 1, 24'h00eb50, 16'h0000, 16'h0000, 1));
    rows.push_back(mk(2'h1, 0, 1, 24'h000008, 16'h0000, 16'h0000, 1));
    rows.push_back(mk(2'h0, 0, 1, 24'h080016, 16'h0000, 16'h0000, 1));
    repeat (10) @(negedge mclk);
    for (i = 0; i < 15; i++) begin
      check(flash_q[i], fl_rst[i]);
    end
    check(temp_unprotect0, 16'h0000);
    rst = 1'b0;
    repeat (6) @(negedge mclk);
    check({15'h0000, id_valid}, 16'h0000);
    expect_op(mk(2'h2, 0, 1, 24'h00f07a, 16'h0000, 16'hf040, 0));
    expect_op(mk(2'h2, 0, 1, 24'h00f078, 16'h0000, 16'h0040, 0));
    flash_init_done = 1'b1;
    i = 0;
    v = 16'hc000;
    while (v[15:14] !== 2'b00 && i < 10) begin
      bus_op(2'h2, 1'b0, 1'b1, 24'h00f07a, 16'h0000, v, e);
      i++;
    end
    check({14'h0000, v[15:14]}, 16'h0000);
    check({12'h000, v[15:12]}, 16'h0003);
    check({4'h0, v[11:0]}, 16'h0040);
    check({15'h0000, id_valid}, 16'h0001);
    foreach (rows[k]) begin
      expect_op(rows[k]);
    end
    expect_op(mk(2'h2, 0, 1, 24'h00f07c, 16'h0000, CHIP_EXP, 0));
    expect_op(mk(2'h2, 0, 1, 24'h00f07e, 16'h0000, MAKER_EXP, 0));
    expect_op(mk(2'h2, 0, 1, 24'h00f07a, 16'h0000, 16'h3040, 0));
    check(temp_unprotect0, 16'ha55a);
    for (i = 0; i < 15; i++) begin
      v = 16'hc300 | 16'(i);
      expect_op(mk(2'h0, 0, 1, fl_addr[i], '0, fl_rst[i], 0));
      expect_op(mk(2'h0, 1, 1, fl_addr[i], v, 16'h0000, 0));
      check(flash_q[i], v);
      expect_op(mk(2'h0, 0, 1, fl_addr[i], 16'h0000, v, 0));
    end
    external_access_pin = 1'b1;
    flash_init_done = 1'b0;
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    check(flash_q[0], 16'h0000);
    check(flash_q[12], 16'hacff);
    check(temp_unprotect0, 16'h0000);
    rst = 1'b0;
    i = 0;
    while (id_valid !== 1'b1 && i < 8) begin
      @(negedge mclk);
      i++;
    end
    check({15'h0000, id_valid}, 16'h0001);
    expect_op(mk(2'h2, 0, 1, 24'h00f07a, 16'h0000, 16'h3040, 0));
    report_and_stop();
  end

endmodule
`default_nettype wire
